// >>> hw/cdf_buf2.sv
`timescale 1ns/1ps

// Two-entry buffer; entry 0 is the output register
module cdf_buf2
  import cdf_pkg::*;
#(
  parameter int W = 101
)
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [1:0] o_count
);

  if (W < 1)
    $error("cdf_buf2: width must be positive");

  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] cnt;
    logic vld;
  } cdf_buf_st_t;

  cdf_buf_st_t q_r;
  cdf_buf_st_t q_nxt;
  logic pop;
  logic push;

  assign pop = q_r.vld && i_out_ready;
  assign push = i_in_valid && (q_r.cnt != 2'h2);

  // Pop shifts entry 1 forward before the push lands; a full buffer still refuses
  // a word in the cycle the sink drains one, as push looks only at the old count
  always_comb
  begin
    q_nxt = q_r;
    if (pop)
    begin
      q_nxt.d0 = q_r.d1;
      q_nxt.cnt = q_r.cnt - 2'h1;
    end
    if (push)
    begin
      if (q_nxt.cnt == 2'h0)
        q_nxt.d0 = i_in_data;
      else
        q_nxt.d1 = i_in_data;
      q_nxt.cnt = q_nxt.cnt + 2'h1;
    end
    q_nxt.vld = (q_nxt.cnt != 2'h0);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign o_in_ready = (q_r.cnt != 2'h2);
  assign o_out_valid = q_r.vld;
  assign o_out_data = q_r.d0;
  assign o_count = q_r.cnt;

endmodule

// >>> hw/cdf_cfg.svh
`ifndef CDF_CFG_SVH
`define CDF_CFG_SVH

// Column characters as the receive aligner stores them
`define CDF_IDLE_BYTE 8'h07
`define CDF_START_BYTE 8'hFB

// Header word layout: check value on top, tag in the middle, length low
`define CDF_HCRC_MSB 63
`define CDF_HCRC_LSB 32
`define CDF_LEN_MSB 15
`define CDF_LEN_LSB 0
`define CDF_HCRC_NBYTES 4'h4

// Byte arithmetic of one 64-bit beat and of the trailing packet check
`define CDF_WORD_BYTES 16'h0008
`define CDF_TAIL_BYTES 16'h0004
`define CDF_FULL_NBYTES 4'h8

// Check-value engine, reflected, no final inversion
`define CDF_CRC_INIT 32'hFFFFFFFF
`define CDF_CRC_POLY 32'hEDB88320

// Read threshold in bytes and the wait before residual words are drained
`define CDF_RD_THRESH 11'h040
`define CDF_DRAIN_WAIT 32
`define CDF_MIN_AVAIL 11'h008

`endif

// >>> hw/cdf_crc32.sv
`timescale 1ns/1ps
`include "cdf_cfg.svh"

// Combinational check-value step over up to eight bytes, MSB byte first
module cdf_crc32
  import cdf_pkg::*;
(
  input wire logic [31:0] i_crc,
  input wire logic [63:0] i_data,
  input wire logic [3:0] i_nbytes,
  output logic [31:0] o_crc
);

  logic [31:0] acc;

  // One byte through the reflected polynomial
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++)
      x = x[0] ? ((x >> 1) ^ `CDF_CRC_POLY) : (x >> 1);
    return x;
  endfunction

  // Bytes beyond the count are skipped, so partial tails need no masking
  always_comb
  begin
    acc = i_crc;
    for (int b = 0; b < 8; b++)
      if (4'(b) < i_nbytes)
        acc = crc_byte(acc, i_data[63 - 8 * b -: 8]);
    o_crc = acc;
  end

endmodule

// >>> hw/cdf_deframer.sv
`timescale 1ns/1ps
`include "cdf_cfg.svh"

module cdf_deframer
  import cdf_pkg::*;
#(
  parameter logic [10:0] RD_THRESH = `CDF_RD_THRESH,
  parameter int DRAIN_WAIT = `CDF_DRAIN_WAIT
)
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_backend_reset_n,
  input wire logic i_dma_sink_ready,
  output logic o_ctl_source_ready,
  output logic o_pkt_first_beat,
  output logic o_pkt_last_beat,
  output logic [2:0] o_last_beat_byte_count,
  output logic [63:0] o_dma_payload,
  output logic [63:0] o_pkt_crc_status,
  input wire logic i_dma_abort_req,
  output logic o_abort_grant,
  input wire logic [10:0] i_fifo_avail_bytes,
  input wire logic [63:0] i_fifo_rd_data,
  output logic o_fifo_rd_en,
  output logic o_dropped_pkt_flag,
  input wire logic i_dropped_flag_clear
);

  localparam int BW = 64 + 1 + 1 + 3 + 32;

  // The threshold must admit at least one whole word and the drain wait must fit the timer count
  if (RD_THRESH < `CDF_MIN_AVAIL)
    $error("cdf_deframer: RD_THRESH below one word");
  if (DRAIN_WAIT < 1 || DRAIN_WAIT > 255)
    $error("cdf_deframer: DRAIN_WAIT out of range");

  typedef struct packed {
    cdf_state_t st;
    logic rd_en;
    logic rv;
    logic [63:0] hdr;
    logic [15:0] rem;
    logic [31:0] crc;
    logic drop;
    logic grant;
    logic [7:0] dcnt;
  } cdf_ctl_st_t;

  cdf_ctl_st_t q_r;
  cdf_ctl_st_t q_nxt;

  logic rst;
  logic [63:0] wd;
  logic [7:0] lane_idle;
  logic is_idle;
  logic is_start;
  logic [31:0] hcrc;
  logic hdr_match;
  logic [31:0] pcrc;
  logic [63:0] beat_data;
  logic is_last;
  logic push;
  logic push_sop;
  logic push_eop;
  logic [2:0] push_cnt;
  logic [31:0] push_stat;
  logic [63:0] push_data;
  logic drop_ev;
  logic thr_ok;
  logic drn_ok;
  logic want;
  logic room;
  logic [BW-1:0] buf_out;
  logic [1:0] buf_cnt;
  logic buf_rdy;
  logic [63:0] hdr_lo;
  logic [31:0] pcrc_seed;

  // Every check below runs on the one clock; all but a_backend_rst rest while in reset
  default clocking cdf_cb @(posedge i_mclk);
  endclocking
  default disable iff (rst);

  // Bytes of this beat that enter the payload check: the last four bytes of
  // the packet carry the sender's own check value and are left out
  function automatic logic [3:0] take_bytes(input logic [15:0] rem);
    if (rem >= `CDF_WORD_BYTES + `CDF_TAIL_BYTES)
      take_bytes = `CDF_FULL_NBYTES;
    else if (rem > `CDF_TAIL_BYTES)
      take_bytes = 4'(rem - `CDF_TAIL_BYTES);
    else
      take_bytes = 4'h0;
  endfunction

  // Backend reset from the DMA acts like the local one
  assign rst = i_reset || !i_backend_reset_n;

  // Read data belongs to the read enable of the previous cycle
  assign wd = i_fifo_rd_data;

  // Column classification of the returning word
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_lane
      assign lane_idle[g] = (wd[8 * g +: 8] == `CDF_IDLE_BYTE);
    end
  endgenerate

  assign is_idle = &lane_idle;
  assign is_start = (wd[63:56] == `CDF_START_BYTE) && (&lane_idle[6:0]);

  // Header check over tag and length, compared with the stored check value
  assign hdr_lo = {wd[31:0], 32'h00000000};
  cdf_crc32 u_hcrc (
    .i_crc(`CDF_CRC_INIT),
    .i_data(hdr_lo),
    .i_nbytes(`CDF_HCRC_NBYTES),
    .o_crc(hcrc)
  );
  assign hdr_match = (hcrc == wd[`CDF_HCRC_MSB:`CDF_HCRC_LSB]);

  // Running payload check; the header beat restarts it
  assign beat_data = (q_r.st == CDF_FIRST) ? q_r.hdr : wd;
  assign pcrc_seed = (q_r.st == CDF_FIRST) ? `CDF_CRC_INIT : q_r.crc;
  cdf_crc32 u_pcrc (
    .i_crc(pcrc_seed),
    .i_data(beat_data),
    .i_nbytes(take_bytes(q_r.rem)),
    .o_crc(pcrc)
  );

  assign is_last = (q_r.rem <= `CDF_WORD_BYTES);

  // Threshold gate and residual drain timer
  assign thr_ok = (i_fifo_avail_bytes >= RD_THRESH);
  assign drn_ok = (q_r.dcnt == 8'(DRAIN_WAIT)) && (i_fifo_avail_bytes >= `CDF_MIN_AVAIL);

  // Room counts the word that this cycle pushes, so a read issued now always
  // finds a free entry when its data returns
  assign buf_rdy = (buf_cnt != 2'h2);
  assign room = (buf_cnt == 2'h0) || ((buf_cnt == 2'h1) && !push);

  // Framing controller
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rv = q_r.rd_en;
    q_nxt.rd_en = 1'b0;
    push = 1'b0;
    push_sop = 1'b0;
    push_eop = 1'b0;
    push_cnt = 3'h0;
    push_stat = 32'h00000000;
    push_data = beat_data;
    drop_ev = 1'b0;
    want = 1'b0;
    if (i_dma_abort_req && (q_r.st != CDF_ABT_END) && (q_r.st != CDF_ABT_WAIT))
    begin
      // An open packet must be closed before the grant
      q_nxt.st = (q_r.st == CDF_DATA) ? CDF_ABT_END : CDF_ABT_WAIT;
    end
    else
    begin
      case (q_r.st)
        CDF_HUNT_IDLE:
        begin
          if (q_r.rv && is_idle)
            q_nxt.st = CDF_HUNT_START;
        end
        CDF_HUNT_START:
        begin
          // A longer idle run keeps waiting for the start column
          if (q_r.rv)
            q_nxt.st = is_start ? CDF_HDR : (is_idle ? CDF_HUNT_START : CDF_HUNT_IDLE);
        end
        CDF_HDR:
        begin
          // A matching check only proves framing of this word; a packet that
          // slipped inside another may still pass once
          if (q_r.rv)
          begin
            q_nxt.hdr = wd;
            q_nxt.rem = wd[`CDF_LEN_MSB:`CDF_LEN_LSB];
            if (hdr_match)
              q_nxt.st = CDF_FIRST;
            else
            begin
              drop_ev = 1'b1;
              q_nxt.st = CDF_HUNT_IDLE;
            end
          end
        end
        CDF_FIRST, CDF_DATA:
        begin
          // Header beat goes out one cycle after its check, as the first beat
          if ((q_r.st == CDF_FIRST) ? buf_rdy : q_r.rv)
          begin
            push = 1'b1;
            push_sop = (q_r.st == CDF_FIRST);
            push_eop = is_last;
            push_cnt = q_r.rem[2:0];
            push_stat = pcrc;
            q_nxt.crc = pcrc;
            q_nxt.rem = is_last ? 16'h0000 : q_r.rem - `CDF_WORD_BYTES;
            q_nxt.st = is_last ? CDF_HUNT_IDLE : CDF_DATA;
          end
        end
        CDF_ABT_END:
        begin
          // Filler beat closes the open packet; its contents carry no data
          if (buf_rdy)
          begin
            push = 1'b1;
            push_eop = 1'b1;
            push_stat = q_r.crc;
            push_data = 64'h0000000000000000;
            q_nxt.st = CDF_ABT_WAIT;
          end
        end
        CDF_ABT_WAIT:
        begin
          // Grant only after every beat has left, held until backend reset
          if (buf_cnt == 2'h0)
            q_nxt.grant = 1'b1;
        end
        default:
        begin
          q_nxt.st = CDF_HUNT_IDLE;
        end
      endcase
    end
    // Set wins over a clear arriving in the same cycle
    q_nxt.drop = (q_r.drop && !i_dropped_flag_clear) || drop_ev;
    // Drain timer runs while words sit below the threshold
    if (thr_ok || (i_fifo_avail_bytes < `CDF_MIN_AVAIL))
      q_nxt.dcnt = 8'h00;
    else if (q_r.dcnt != 8'(DRAIN_WAIT))
      q_nxt.dcnt = q_r.dcnt + 8'h01;
    // One read in flight at a time: the state that receives the word is known
    // when the read is issued, at the cost of half the peak read rate
    case (q_nxt.st)
      CDF_HUNT_IDLE, CDF_HUNT_START, CDF_HDR, CDF_DATA: want = 1'b1;
      default: want = 1'b0;
    endcase
    q_nxt.rd_en = !q_r.rd_en && want && i_dma_sink_ready && (thr_ok || drn_ok) && room;
  end

  always_ff @(posedge i_mclk)
  begin
    if (rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  // Output buffer holds beats while the DMA stalls
  cdf_buf2 #(
    .W(BW)
  ) u_buf (
    .i_mclk(i_mclk),
    .i_reset(rst),
    .i_in_valid(push),
    .o_in_ready(),
    .i_in_data({push_data, push_sop, push_eop, push_cnt, push_stat}),
    .o_out_valid(o_ctl_source_ready),
    .i_out_ready(i_dma_sink_ready),
    .o_out_data(buf_out),
    .o_count(buf_cnt)
  );

  // Beat fields unpacked straight from the output register
  assign o_dma_payload = buf_out[BW-1 -: 64];
  assign o_pkt_first_beat = buf_out[36];
  assign o_pkt_last_beat = buf_out[35];
  assign o_last_beat_byte_count = buf_out[34:32];
  assign o_pkt_crc_status = {32'h00000000, buf_out[31:0]};
  assign o_fifo_rd_en = q_r.rd_en;
  assign o_dropped_pkt_flag = q_r.drop;
  assign o_abort_grant = q_r.grant;

  // Stalled beats must not change under the DMA
  a_stall_hold: assert property (o_ctl_source_ready && !i_dma_sink_ready |=>
    o_ctl_source_ready && $stable(o_dma_payload) && $stable(o_pkt_last_beat))
    else $error("payload changed during stall");

  // Reads follow DMA readiness of the cycle before
  a_rd_gate: assert property (o_fifo_rd_en |-> $past(i_dma_sink_ready))
    else $error("read issued without DMA ready");

  // Below threshold only the drain timer may allow a read
  a_rd_thresh: assert property (!thr_ok && !drn_ok && !o_fifo_rd_en |=> !o_fifo_rd_en)
    else $error("read below threshold without drain");

  // Hunting words never enter the buffer
  a_hunt_silent: assert property ((q_r.st inside {CDF_HUNT_IDLE, CDF_HUNT_START, CDF_HDR}) |-> !push)
    else $error("framing word forwarded");

  // Start column and header arrival leave two quiet cycles before the header is checked
  a_hdr_bubble: assert property (q_r.st == CDF_HUNT_START && q_r.rv && is_start |->
    !push ##1 !push ##1 (q_r.st == CDF_HDR || q_r.st == CDF_FIRST))
    else $error("data pushed in header bubble");

  // A bad header sets the flag and restarts the hunt
  a_drop_flag: assert property (q_r.st == CDF_HDR && q_r.rv && !hdr_match && !i_dma_abort_req |=>
    o_dropped_pkt_flag && q_r.st == CDF_HUNT_IDLE && !push)
    else $error("bad header not dropped");

  // The flag holds until cleared
  a_flag_sticky: assert property (o_dropped_pkt_flag && !i_dropped_flag_clear |=> o_dropped_pkt_flag)
    else $error("dropped flag lost");

  // A good header becomes the first beat with its length loaded
  a_hdr_accept: assert property (q_r.st == CDF_HDR && q_r.rv && hdr_match && !i_dma_abort_req |=>
    q_r.st == CDF_FIRST && q_r.rem == $past(wd[15:0]))
    else $error("good header not accepted");

  // The first-beat marker only rides on the header beat
  a_first_beat: assert property (push && push_sop |-> q_r.st == CDF_FIRST && beat_data == q_r.hdr)
    else $error("first beat marker misplaced");

  // The last beat carries the remaining byte count
  a_last_count: assert property (push && push_eop && q_r.st == CDF_DATA |->
    q_r.rem <= `CDF_WORD_BYTES && push_cnt == q_r.rem[2:0])
    else $error("last beat count wrong");

  // Grant comes only with an empty buffer after an abort
  a_abort_grant: assert property ($rose(o_abort_grant) |->
    !o_ctl_source_ready && $past(q_r.st == CDF_ABT_WAIT))
    else $error("abort granted with data pending");

  // Backend reset clears every output
  // The default disable would mute this check exactly when it matters
  a_backend_rst: assert property (@(posedge i_mclk) disable iff (1'b0) !i_backend_reset_n |=>
    !o_ctl_source_ready && !o_fifo_rd_en && !o_abort_grant && !o_dropped_pkt_flag)
    else $error("backend reset ignored");

  c_first_beat: cover property (o_ctl_source_ready && i_dma_sink_ready && o_pkt_first_beat);
  c_drop: cover property (drop_ev);
  c_abort_mid: cover property (q_r.st == CDF_ABT_END ##[1:8] o_abort_grant);
  c_drain: cover property (o_fifo_rd_en && !$past(thr_ok));

endmodule

// >>> hw/cdf_pkg.sv
package cdf_pkg;

  // Framing controller states
  typedef enum logic [2:0] {
    CDF_HUNT_IDLE,
    CDF_HUNT_START,
    CDF_HDR,
    CDF_FIRST,
    CDF_DATA,
    CDF_ABT_END,
    CDF_ABT_WAIT
  } cdf_state_t;

endpackage

// >>> sim/cdf_deframer_tb_top.sv
`timescale 1ns/1ps
`include "cdf_cfg.svh"

module cdf_deframer_tb_top;
  import cdf_pkg::*;

  typedef struct packed {logic [63:0] d; logic f; logic l; logic [2:0] c; logic [31:0] s;} cdf_beat_t;
  typedef struct {logic [15:0] len; logic good; logic stl; logic [2:0] cnt; logic flag;} cdf_row_t;

  logic i_mclk, i_reset, i_backend_reset_n, i_dma_sink_ready, i_dma_abort_req, i_dropped_flag_clear;
  logic o_ctl_source_ready, o_pkt_first_beat, o_pkt_last_beat, o_abort_grant, o_fifo_rd_en, o_dropped_pkt_flag;
  logic [2:0] o_last_beat_byte_count;
  logic [63:0] o_dma_payload, o_pkt_crc_status, fifo_data;
  logic [10:0] fifo_avail;
  logic sink_en, stall, aborting, saw_first, saw_last, held;
  logic [63:0] held_d;
  int err_total, num_checks, cyc, rd_cnt;
  cdf_beat_t exp_q[$];
  // Length, header good, stall, then expected byte count and flag
  cdf_row_t rows [6] = '{'{16'h0010, 1'b1, 1'b0, 3'h0, 1'b0}, '{16'h000D, 1'b1, 1'b1, 3'h5, 1'b0},
    '{16'h0019, 1'b1, 1'b0, 3'h1, 1'b0}, '{16'h0018, 1'b0, 1'b0, 3'h0, 1'b1},
    '{16'h0030, 1'b1, 1'b1, 3'h0, 1'b0}, '{16'h000C, 1'b1, 1'b0, 3'h4, 1'b0}};

  cdf_deframer #(.RD_THRESH(11'h020), .DRAIN_WAIT(4)) cdf_deframer_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_backend_reset_n(i_backend_reset_n), .i_dma_sink_ready(i_dma_sink_ready),
    .o_ctl_source_ready(o_ctl_source_ready), .o_pkt_first_beat(o_pkt_first_beat),
    .o_pkt_last_beat(o_pkt_last_beat), .o_last_beat_byte_count(o_last_beat_byte_count),
    .o_dma_payload(o_dma_payload), .o_pkt_crc_status(o_pkt_crc_status), .i_dma_abort_req(i_dma_abort_req),
    .o_abort_grant(o_abort_grant), .i_fifo_avail_bytes(fifo_avail), .i_fifo_rd_data(fifo_data),
    .o_fifo_rd_en(o_fifo_rd_en), .o_dropped_pkt_flag(o_dropped_pkt_flag),
    .i_dropped_flag_clear(i_dropped_flag_clear));

  cdf_fifo_model cdf_fifo_model_inst (.i_mclk(i_mclk), .i_reset(i_reset || !i_backend_reset_n),
    .i_rd_en(o_fifo_rd_en), .o_avail_bytes(fifo_avail), .o_rd_data(fifo_data));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // Reflected check-value step over one byte
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ `CDF_CRC_POLY) : (c >> 1);
    return c;
  endfunction

  // Store one framed packet and queue the beats it should yield
  task automatic send_pkt(input logic [15:0] len, input logic [15:0] tag, input logic good, input logic [2:0] cnt);
    logic [31:0] hc;
    logic [31:0] pc;
    logic [63:0] w;
    int nb;
    hc = `CDF_CRC_INIT;
    pc = `CDF_CRC_INIT;
    nb = (int'(len) + 7) / 8;
    for (int k = 3; k >= 0; k--)
      hc = crc_byte(hc, 8'({tag, len} >> (8 * k)));
    cdf_fifo_model_inst.push(64'h0707070707070707);
    cdf_fifo_model_inst.push(64'hFB07070707070707);
    for (int b = 0; b < nb; b++)
    begin
      w = (b == 0) ? {good ? hc : ~hc, tag, len} : {tag, 16'(b), 32'hA5C39E10 + 32'(b)};
      for (int k = 0; k < 8; k++)
        if (b * 8 + k < int'(len) - 4)
          pc = crc_byte(pc, w[63 - 8 * k -: 8]);
      cdf_fifo_model_inst.push(w);
      if (good)
        exp_q.push_back('{w, b == 0, b == nb - 1, cnt, pc});
    end
  endtask

  task automatic take_beat(input cdf_beat_t e);
    check(o_dma_payload, e.d, "payload");
    check(64'(o_pkt_first_beat), 64'(e.f), "first marker");
    check(64'(o_pkt_last_beat), 64'(e.l), "last marker");
    if (e.l)
    begin
      check(64'(o_last_beat_byte_count), 64'(e.c), "byte count");
      check(o_pkt_crc_status, {32'h0, e.s}, "status value");
    end
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while ((exp_q.size() != 0 || cdf_fifo_model_inst.q.size() != 0 || o_ctl_source_ready) && t < 2000)
    begin
      step(1);
      t++;
    end
    step(4);
    check(64'(t < 2000), 64'h1, "traffic stuck");
  endtask

  task automatic bk_reset();
    i_backend_reset_n = 1'b0;
    i_dma_abort_req = 1'b0;
    step(2);
    check({o_ctl_source_ready, o_abort_grant, o_fifo_rd_en, o_dropped_pkt_flag}, 64'h0, "outputs in reset");
    i_backend_reset_n = 1'b1;
    exp_q.delete();
    step(1);
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever
      #25 i_mclk = ~i_mclk;
  end

  // Sink readiness follows the scenario; a cycle ceiling cuts a hang short
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    i_dma_sink_ready <= #1 sink_en && !(stall && cyc[1]);
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // Monitor: every taken beat outside an abort is compared; stalled beats must not move
  always @(posedge i_mclk)
  begin
    if (o_fifo_rd_en)
      rd_cnt++;
    if (i_reset || !i_backend_reset_n)
      held = 1'b0;
    else
    begin
      if (held)
        check(o_dma_payload, held_d, "stalled beat moved");
      held = o_ctl_source_ready && !i_dma_sink_ready;
      held_d = o_dma_payload;
      if (o_ctl_source_ready && i_dma_sink_ready)
      begin
        saw_first = saw_first | o_pkt_first_beat;
        if (aborting)
          saw_last = saw_last | o_pkt_last_beat;
        else if (exp_q.size() == 0)
          check(64'h1, 64'h0, "beat not expected");
        else
          take_beat(exp_q.pop_front());
      end
    end
  end

  initial
  begin
    {i_reset, i_backend_reset_n, sink_en} = 3'b111;
    {i_dma_sink_ready, i_dma_abort_req, i_dropped_flag_clear, stall, aborting, saw_first, saw_last, held} = 8'h00;
    {err_total, num_checks, cyc, rd_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
    step(12);
    check({o_ctl_source_ready, o_abort_grant, o_fifo_rd_en, o_dropped_pkt_flag}, 64'h0, "outputs in reset");
    i_reset = 1'b0;
    foreach (rows[i])
    begin
      stall = rows[i].stl;
      send_pkt(rows[i].len, 16'h0100 + 16'(i), rows[i].good, rows[i].cnt);
      wait_idle();
      check(64'(o_dropped_pkt_flag), 64'(rows[i].flag), "dropped flag");
      i_dropped_flag_clear = 1'b1;
      step(1);
      i_dropped_flag_clear = 1'b0;
      step(1);
      check(64'(o_dropped_pkt_flag), 64'h0, "flag after clear");
    end
    // No reads while the sink is not ready
    {sink_en, stall} = 2'b00;
    step(2);
    rd_cnt = 0;
    send_pkt(16'h0020, 16'h0200, 1'b1, 3'h0);
    step(20);
    check(64'(rd_cnt), 64'h0, "read without sink");
    sink_en = 1'b1;
    wait_idle();
    // Two words below threshold: held back first, then drained
    rd_cnt = 0;
    cdf_fifo_model_inst.push(64'h0707070707070707);
    cdf_fifo_model_inst.push(64'hFB07070707070707);
    step(3);
    check(64'(rd_cnt), 64'h0, "read below threshold");
    step(30);
    check(64'(cdf_fifo_model_inst.q.size()), 64'h0, "residual words");
    bk_reset();
    // Abort with a packet open under a stalling sink
    {stall, saw_first, saw_last} = 3'b100;
    send_pkt(16'h0050, 16'h0300, 1'b1, 3'h0);
    repeat (300) if (!saw_first) step(1);
    aborting = 1'b1;
    i_dma_abort_req = 1'b1;
    repeat (300) if (!o_abort_grant) step(1);
    check(64'(o_abort_grant), 64'h1, "abort grant");
    check(64'(saw_last), 64'h1, "closing beat before grant");
    bk_reset();
    {aborting, stall} = 2'b00;
    // Reception resumes, two packets back to back
    send_pkt(16'h0011, 16'h0400, 1'b1, 3'h1);
    send_pkt(16'h001E, 16'h0401, 1'b1, 3'h6);
    wait_idle();
    wrap_up();
  end
endmodule

// >>> sim/cdf_fifo_model.sv
`timescale 1ns/1ps

// Read port of the packet store: one word per request, answered a cycle later
module cdf_fifo_model
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_rd_en,
  output logic [10:0] o_avail_bytes,
  output logic [63:0] o_rd_data
);
  logic [63:0] q[$];

  // Count in whole words, capped at what the count field can hold
  function automatic logic [10:0] avail_of(input int n);
    return (n > 255) ? 11'h7F8 : 11'(n * 8);
  endfunction

  task automatic upd();
    o_avail_bytes = avail_of(q.size());
  endtask

  task automatic push(input logic [63:0] w);
    q.push_back(w);
    upd();
  endtask

  initial
  begin
    o_avail_bytes = 11'h000;
    o_rd_data = 64'h0;
  end

  // Between answers the bus flips, so a stale word is never mistaken for a fresh one
  always @(posedge i_mclk)
  begin
    if (i_reset)
      q.delete();
    if (i_rd_en && !i_reset && q.size() != 0)
      o_rd_data <= q.pop_front();
    else
      o_rd_data <= ~o_rd_data;
    // Non-blocking, so the design's read decision at this edge sees the old count
    o_avail_bytes <= avail_of(q.size());
  end
endmodule
